/* design/wdt2sr_defines.svh */
// constants for the two stage reload watchdog
`ifndef WDT2SR_DEFINES_SVH
`define WDT2SR_DEFINES_SVH
// register byte addresses (printed offsets are not all word multiples: index * 4)
`define WDT2SR_IDX_PWRCTL 8'h87
`define WDT2SR_IDX_COUNT 8'hFF
`define WDT2SR_ADDR_PWRCTL 12'h21C
`define WDT2SR_ADDR_COUNT 12'h3FC
// power control field positions
`define WDT2SR_BIT_UNLOCK 4
`define WDT2SR_BIT_PDOWN 1
// timing
`define WDT2SR_MC_DIV 3'h6
`define WDT2SR_MC_LAST 3'h5
`define WDT2SR_PRE_MAX 11'h7FF
`define WDT2SR_CNT_MAX 8'hFF
`define WDT2SR_PULSE_MC 2'h3
`endif

/* design/wdt2sr_pkg.sv */
// types for the two stage reload watchdog
package wdt2sr_pkg;
  typedef enum logic [1:0] {
    WDT2SR_ST_RUN = 2'b00,
    WDT2SR_ST_PULSE = 2'b01
  } wdt2sr_state_t;
endpackage

/* design/wdt2sr_sync.sv */
// three stage input synchroniser, change accepted when last two agree
`timescale 1ns/100ps
module wdt2sr_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic out_reg;
  // s1 is read only by s2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      out_reg <= 1'b1;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        out_reg <= s3_reg;
      end
    end
  end
  assign dout = out_reg;
endmodule

/* design/wdt2sr_prescaler.sv */
// machine cycle divider and 11-bit prescaler
`timescale 1ns/100ps
`include "wdt2sr_defines.svh"
module wdt2sr_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  output logic mc_tick,
  output logic wrap_tick
);
  logic [2:0] div_reg;
  logic [10:0] pre_reg;
  wire mc_end = (div_reg == `WDT2SR_MC_LAST);
  wire pre_end = (pre_reg == `WDT2SR_PRE_MAX);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 3'h0;
      pre_reg <= 11'h000;
    end else if (clear) begin
      div_reg <= 3'h0;
      pre_reg <= 11'h000;
    end else begin
      div_reg <= mc_end ? 3'h0 : div_reg + 3'h1; // RQ2
      if (mc_end) begin
        pre_reg <= pre_reg + 11'h001; // RQ1
      end
    end
  end
  assign mc_tick = mc_end;
  assign wrap_tick = mc_end && pre_end; // RQ3
endmodule

/* design/wdt2sr_top.sv */
// watchdog timer with two stage reload, apb register slave
//
// Behaviour
// RQ1: counter is 8 bits, advanced by carry of an 11-bit prescaler.
// RQ2: prescaler advances once per machine cycle, one sixth of the clock.
// RQ3: counter increments once every 6 x 2048 clock periods.
// RQ4: counter overflow produces an internal chip reset pulse.
// RQ5: overflow also drives a three machine cycle reset pin pulse; the code holds the pin 19 clocks, one clock plus three machine cycles.
// RQ6: low strap enables watchdog; software cannot disable it.
// RQ7: high strap disables watchdog; no overflow reset occurs.
// RQ8: counter writes ignored while unlock flag bit 4 is clear.
// RQ9: accepted counter write clears the unlock flag automatically.
// RQ10: counter counts up from loaded value; 00 longest, FF shortest.
// RQ11: prescaler and counter keep running in idle mode.
// RQ12: with watchdog enabled, power-down bit cannot be set, stays zero.
// RQ13: software reloads the counter before the interval elapses.
// RQ14: counter at index FF, power control at index 87.
// RQ15: system reset clears prescaler, counter and unlock flag.
`timescale 1ns/100ps
`include "wdt2sr_defines.svh"
module wdt2sr_top
  import wdt2sr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_enable_strap_n,
  input wire logic idle_mode,
  output logic chip_reset_req,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic powerdown_req
);
  // ****************************************
  // strap synchroniser and prescaler
  // ****************************************
  logic strap_n_sync;
  logic mc_tick;
  logic wrap_tick;
  logic wd_clear;
  wdt2sr_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(watchdog_enable_strap_n),
    .dout(strap_n_sync)
  );
  // idle mode is not an input to the counting path: it keeps running
  wdt2sr_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .clear(wd_clear),
    .mc_tick(mc_tick),
    .wrap_tick(wrap_tick)
  ); // RQ11
  // ****************************************
  // state
  // ****************************************
  logic [7:0] watchdog_counter_reg;
  logic reload_unlock_flag_reg;
  logic powerdown_request_bit_reg;
  logic [7:0] pwrctl_other_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic chip_reset_reg;
  logic pin_reg;
  logic [1:0] pulse_cnt_reg;
  logic idle_seen_reg;
  wdt2sr_state_t state_reg;
  // ****************************************
  // decode
  // ****************************************
  wire wd_enabled = !strap_n_sync; // RQ6 RQ7
  wire setup = psel && !penable;
  wire hit_pwrctl = (paddr == `WDT2SR_ADDR_PWRCTL); // RQ14
  wire hit_count = (paddr == `WDT2SR_ADDR_COUNT); // RQ14
  wire mapped = hit_pwrctl || hit_count;
  wire wr_pwrctl = setup && pwrite && hit_pwrctl && pstrb[0];
  wire wr_count = setup && pwrite && hit_count && pstrb[0];
  wire count_load = wr_count && reload_unlock_flag_reg; // RQ8
  wire overflow = wd_enabled && wrap_tick && (watchdog_counter_reg == `WDT2SR_CNT_MAX); // RQ4
  wire [7:0] pwrctl_view = {pwrctl_other_reg[7:5], reload_unlock_flag_reg,
                            pwrctl_other_reg[3:2], powerdown_request_bit_reg,
                            pwrctl_other_reg[0]};
  wire [7:0] rd_byte = hit_pwrctl ? pwrctl_view : (hit_count ? watchdog_counter_reg : 8'h00);
  assign wd_clear = chip_reset_reg; // internal reset restarts the timebase
  // ****************************************
  // apb slave: answers one cycle after setup
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
  // ****************************************
  // watchdog counter and power control
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_counter_reg <= 8'h00; // RQ15
      reload_unlock_flag_reg <= 1'b0; // RQ15
      powerdown_request_bit_reg <= 1'b0;
      pwrctl_other_reg <= 8'h00;
    end else if (chip_reset_reg) begin
      watchdog_counter_reg <= 8'h00; // RQ4
      reload_unlock_flag_reg <= 1'b0;
      powerdown_request_bit_reg <= 1'b0;
      pwrctl_other_reg <= 8'h00;
    end else begin
      if (count_load) begin
        watchdog_counter_reg <= pwdata[7:0]; // RQ10
      end else if (wrap_tick) begin
        watchdog_counter_reg <= watchdog_counter_reg + 8'h01; // RQ1 RQ3 RQ10
      end
      // a power control write in the same cycle as a load: the load's auto clear wins
      if (count_load) begin
        reload_unlock_flag_reg <= 1'b0; // RQ9
      end else if (wr_pwrctl) begin
        reload_unlock_flag_reg <= pwdata[`WDT2SR_BIT_UNLOCK];
      end
      if (wr_pwrctl) begin
        powerdown_request_bit_reg <= pwdata[`WDT2SR_BIT_PDOWN] && !wd_enabled; // RQ12
        pwrctl_other_reg <= pwdata[7:0];
      end else if (wd_enabled) begin
        powerdown_request_bit_reg <= 1'b0; // RQ12
      end
    end
  end
  // ****************************************
  // reset pulse generator
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= WDT2SR_ST_RUN;
      chip_reset_reg <= 1'b0;
      pin_reg <= 1'b0;
      pulse_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        WDT2SR_ST_RUN: begin
          chip_reset_reg <= 1'b0;
          if (overflow) begin
            state_reg <= WDT2SR_ST_PULSE;
            chip_reset_reg <= 1'b1; // RQ4
            pin_reg <= 1'b1; // RQ5
            pulse_cnt_reg <= 2'h0;
          end
        end
        WDT2SR_ST_PULSE: begin
          // pin pulse is held for 19 clocks, one clock plus three machine cycles after the divider restart; internal reset lasts one clock
          chip_reset_reg <= 1'b0;
          if (mc_tick) begin
            if (pulse_cnt_reg == `WDT2SR_PULSE_MC - 2'h1) begin
              state_reg <= WDT2SR_ST_RUN;
              pin_reg <= 1'b0; // RQ5
            end else begin
              pulse_cnt_reg <= pulse_cnt_reg + 2'h1;
            end
          end
        end
        default: begin
          state_reg <= WDT2SR_ST_RUN;
          pin_reg <= 1'b0;
          chip_reset_reg <= 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_seen_reg <= 1'b0;
    end else begin
      idle_seen_reg <= idle_mode;
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign chip_reset_req = chip_reset_reg;
  assign reset_pin_out = pin_reg;
  assign reset_pin_oe = pin_reg;
  assign powerdown_req = powerdown_request_bit_reg;
endmodule

/* sim/wdt2sr_chk_sva.sv */
// assertions for the two stage reload watchdog
`timescale 1ns/100ps
module wdt2sr_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic watchdog_enable_strap_n,
  input wire logic chip_reset_req,
  input wire logic reset_pin_out,
  input wire logic powerdown_req
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  // eight cycles covers the strap synchroniser latency
  sequence en_s; !watchdog_enable_strap_n [*8]; endsequence
  sequence dis_s; watchdog_enable_strap_n [*8]; endsequence
  // internal reset also restarts the machine cycle divider: pin stands 19 clocks
  sequence pin_s;
    reset_pin_out [*8] ##1 reset_pin_out [*8] ##1 reset_pin_out [*3] ##1 !reset_pin_out;
  endsequence
  bus_answer_a: assert property (setup_s |=> pready) else $error("no answer after setup");
  bus_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  bus_error_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  read_data_a: assert property (pready || prdata == 32'h0) else $error("read data not idle");
  chip_pulse_a: assert property (chip_reset_req |=> !chip_reset_req)
    else $error("chip reset not one cycle");
  pin_width_a: assert property ($rose(reset_pin_out) |-> pin_s)
    else $error("reset pin pulse width wrong");
  pdown_block_a: assert property (en_s |-> !powerdown_req)
    else $error("power-down set while enabled");
  no_reset_a: assert property (dis_s |-> !chip_reset_req)
    else $error("reset while disabled");
endmodule

/* sim/tb.sv */
// self-checking bench for the two stage reload watchdog
`timescale 1ns/100ps
`include "wdt2sr_defines.svh"
module tb;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic err;} wdt2sr_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic watchdog_enable_strap_n = 1'b0, idle_mode = 1'b0, er;
  logic pready, pslverr, chip_reset_req, reset_pin_out, reset_pin_oe, powerdown_req;
  int error_cnt = 0, n_checks = 0, n, hits = 0;
  wdt2sr_row_t rows [0:9] = '{
    '{1'b1, 12'h21C, 8'h10, 8'h00, 1'b0},
    '{1'b0, 12'h21C, 8'h00, 8'h10, 1'b0},
    '{1'b1, 12'h3FC, 8'h80, 8'h00, 1'b0},
    '{1'b0, 12'h3FC, 8'h00, 8'h80, 1'b0},
    '{1'b0, 12'h21C, 8'h00, 8'h00, 1'b0},
    '{1'b1, 12'h3FC, 8'h40, 8'h00, 1'b0},
    '{1'b0, 12'h3FC, 8'h00, 8'h80, 1'b0},
    '{1'b1, 12'h21C, 8'h02, 8'h00, 1'b0},
    '{1'b0, 12'h21C, 8'h00, 8'h00, 1'b0},
    '{1'b0, 12'h000, 8'h00, 8'h00, 1'b1}};
  wdt2sr_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .watchdog_enable_strap_n, .idle_mode, .chip_reset_req, .reset_pin_out,
    .reset_pin_oe, .powerdown_req);
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) if (chip_reset_req === 1'b1) hits++;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("rdata", rd, {24'h000000, rows[i].e});
      chk("slverr", {31'h0, er}, {31'h0, rows[i].err});
    end
    // ****************
    // overflow, idle must not stop counting
    // ****************
    idle_mode <= 1'b1;
    apb(1'b1, `WDT2SR_ADDR_PWRCTL, 8'h10);
    apb(1'b1, `WDT2SR_ADDR_COUNT, 8'hFF);
    wait_hi(chip_reset_req, 12400);
    chk("overflow", {31'h0, chip_reset_req}, 32'h1);
    wait_hi(reset_pin_out, 30);
    chk("pin", {30'h0, reset_pin_out, reset_pin_oe}, 32'h3);
    repeat (30) @(posedge pclk);
    apb(1'b0, `WDT2SR_ADDR_COUNT, 8'h00);
    chk("count", rd, 32'h0);
    apb(1'b0, `WDT2SR_ADDR_PWRCTL, 8'h00);
    chk("pwrctl", rd, 32'h0);
    // ****************
    // strap disabled, then enabled again
    // ****************
    watchdog_enable_strap_n <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b1, `WDT2SR_ADDR_PWRCTL, 8'h12);
    apb(1'b0, `WDT2SR_ADDR_PWRCTL, 8'h00);
    chk("pwrctl", rd, 32'h12);
    apb(1'b1, `WDT2SR_ADDR_COUNT, 8'hFF);
    n = hits;
    repeat (24700) @(posedge pclk);
    chk("hits", 32'(hits - n), 32'h0);
    chk("pdown", {31'h0, powerdown_req}, 32'h1);
    watchdog_enable_strap_n <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("pdown", {31'h0, powerdown_req}, 32'h0);
    // ****************
    // mid-run reset
    // ****************
    apb(1'b1, `WDT2SR_ADDR_PWRCTL, 8'h10);
    apb(1'b1, `WDT2SR_ADDR_COUNT, 8'h55);
    apb(1'b1, `WDT2SR_ADDR_PWRCTL, 8'h10);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, `WDT2SR_ADDR_COUNT, 8'h00);
    chk("count", rd, 32'h0);
    apb(1'b0, `WDT2SR_ADDR_PWRCTL, 8'h00);
    chk("pwrctl", rd, 32'h0);
    wrap_up;
  end
endmodule
bind wdt2sr_top wdt2sr_chk i_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .watchdog_enable_strap_n, .chip_reset_req, .reset_pin_out, .powerdown_req);
